/* shared/nand_status_regs.vh */
// Summary of operation
// R1: eight-bit status byte readable any time by get-features 0Fh at address C0h.
// R2: driver byte written by set-features 1Fh and read by 0Fh, both at D0h.
// R3: ecc code 00 means no errors; 10 means more than eight, uncorrected.
// R4: ecc code 01 with extension 00/01/10/11 means <=4, 5, 6, 7 corrected.
// R5: ecc code 11 means exactly eight errors found and corrected.
// R6: drive level 00=100% default, 01=75%, 10=50%, 11=25%.
// R7: one-time region is ten pages, 02h to 0Bh, while one-time access is on.
// R8: host programs one-time pages in ascending order with load 02h then execute 10h.
// R9: one-time pages read by page-read 13h, data out by any cache-read variant.
// R10: access bit 0 gives normal operation; access 1 lock 0 allows read and program.
// R11: access and lock set, write enable, execute 10h makes lock permanent.
// R12: lock already 1 at power-on allows only reads of the one-time region.
// R13: one-time region is never erased and refuses programming once locked.
// R14: one-time data gets the same ecc protection as normal pages.
// R15: host sets access bit via 1Fh before one-time program or read.
// R16: factory bad blocks carry 00h at spare byte 2048 of first page.
// R17: host treats any first spare byte other than FFh as a bad block.
// R18: at least 4016 of 4096 blocks per die stay valid over life.
// R19: busy bit is 1 during program execute, page read, erase or reset.
// R20: write latch set by 06h, cleared by 04h, needed before program or erase.
// R21: ecc fields update at each page read completion and hold until next or reset.
`ifndef NAND_STATUS_REGS_VH
`define NAND_STATUS_REGS_VH

// commands
`define CMD_GET_FEAT 8'h0f
`define CMD_SET_FEAT 8'h1f
`define CMD_WR_EN 8'h06
`define CMD_WR_DIS 8'h04
`define CMD_PAGE_READ 8'h13
`define CMD_PROG_LOAD 8'h02
`define CMD_PROG_EXEC 8'h10
`define CMD_BLOCK_ERASE 8'hd8
`define CMD_SOFT_RESET 8'hff

// feature addresses
`define FEAT_STATUS 8'hc0
`define FEAT_DRIVER 8'hd0
`define FEAT_ONETIME 8'hb0

// status byte fields
`define ST_BUSY 0
`define ST_WLATCH 1
`define ST_EFAIL 2
`define ST_PFAIL 3
`define ST_ECC_LO 4
`define ST_ECC_HI 5
`define ST_EXT_LO 6
`define ST_EXT_HI 7

// driver byte field and one-time config fields
`define DRV_LO 5
`define DRV_HI 6
`define DRV_RESET 2'h0
`define OT_EN_BIT 6
`define OT_LOCK_BIT 7

// ecc result codes
`define ECC_NONE 2'h0
`define ECC_FIXED 2'h1
`define ECC_UNCORR 2'h2
`define ECC_EIGHT 2'h3
`define ECC_CNT_EIGHT 4'h8
`define ECC_CNT_FOUR 4'h4

// one-time page window
`define OT_FIRST_PAGE 16'h0002
`define OT_LAST_PAGE 16'h000b

// operation kinds on the array port
`define OP_READ 2'h0
`define OP_PROG 2'h1
`define OP_ERASE 2'h2

// array facts the block relies on
// R16 factory bad-block mark
`define BAD_MARK 8'h00
`define ERASED_BYTE 8'hff
`define BAD_MARK_COL 12'h800
// R18 good-block floor per die
`define MIN_GOOD_BLOCKS 13'd4016
`define TOTAL_BLOCKS 13'd4096

// reset command busy time
`define CLK_MHZ 100
`define RST_BUSY_NS 500
`define RST_BUSY_CYC ((`RST_BUSY_NS * `CLK_MHZ) / 1000)

`endif

/* src/serial_nand_status_otp_ctrl.v */
`timescale 1ns/1ns
`include "nand_status_regs.vh"

module serial_nand_status_otp_ctrl (
  input wire core_clk,
  input wire rst,
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  input wire op_done,
  input wire [3:0] ecc_count,
  input wire ecc_uncorr,
  input wire op_fail,
  input wire nv_lock,
  output reg miso,
  output reg miso_oe_n,
  output reg op_start,
  output reg [1:0] op_kind,
  output reg [23:0] op_row,
  output reg op_onetime,
  output reg lock_commit,
  output reg [1:0] drive_level,
  output reg op_in_progress
);

  localparam integer RST_CYC_FULL = `RST_BUSY_CYC;
  localparam [5:0] RST_CYC = RST_CYC_FULL[5:0];
  localparam [2:0] LAST_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // ecc count to status code, used for code and extension
  function [3:0] ecc_code;
    input [3:0] cnt;
    input uncorr;
    begin
      // R3 none or uncorrectable
      if (uncorr)
        ecc_code = {2'h0, `ECC_UNCORR};
      else if (cnt == 4'h0)
        ecc_code = {2'h0, `ECC_NONE};
      // R5 exactly eight
      else if (cnt == `ECC_CNT_EIGHT)
        ecc_code = {2'h0, `ECC_EIGHT};
      // R4 extension carries five to seven
      else if (cnt <= `ECC_CNT_FOUR)
        ecc_code = {2'h0, `ECC_FIXED};
      else
        ecc_code = {cnt[1:0], `ECC_FIXED};
    end
  endfunction

  function in_onetime;
    input [15:0] page;
    begin
      in_onetime = (page >= `OT_FIRST_PAGE) && (page <= `OT_LAST_PAGE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link pins pass two flops before use
  reg sclk_s1, sclk_s2, sclk_d;
  reg cs_s1, cs_s2, cs_d;
  reg mosi_s1, mosi_s2;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  wire sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
  wire sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
  wire frame_end = cs_s2 & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // byte assembly
  reg [2:0] bit_cnt;
  reg [2:0] byte_cnt;
  reg [6:0] shift_in;
  reg [7:0] cmd;
  reg [7:0] feat_addr;
  reg [23:0] row;
  wire [7:0] rx_byte = {shift_in, mosi_s2};
  wire byte_done = sclk_rise && (bit_cnt == LAST_BIT);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shift_in <= 7'h00;
      cmd <= 8'h00;
      feat_addr <= 8'h00;
      row <= 24'h000000;
    end else if (cs_s2) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      shift_in <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == LAST_BIT) begin
        if (byte_cnt != 3'h7)
          byte_cnt <= byte_cnt + 3'h1;
        case (byte_cnt)
          3'h0: cmd <= rx_byte;
          3'h1: begin
            feat_addr <= rx_byte;
            row[23:16] <= rx_byte;
          end
          3'h2: row[15:8] <= rx_byte;
          3'h3: row[7:0] <= rx_byte;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feature state and operation control
  reg wlatch, e_fail, p_fail;
  reg [1:0] ecc_res;
  reg [1:0] ecc_ext;
  reg ot_en, ot_lock, ot_locked;
  reg lock_seen;
  reg [5:0] rst_cnt;
  reg rst_busy;

  wire [7:0] status_byte;
  assign status_byte[`ST_BUSY] = op_in_progress;
  assign status_byte[`ST_WLATCH] = wlatch;
  assign status_byte[`ST_EFAIL] = e_fail;
  assign status_byte[`ST_PFAIL] = p_fail;
  assign status_byte[`ST_ECC_HI:`ST_ECC_LO] = ecc_res;
  assign status_byte[`ST_EXT_HI:`ST_EXT_LO] = ecc_ext;

  wire [7:0] driver_byte = {1'b0, drive_level, 5'h00};
  // lock reads set once committed, even after a soft reset
  wire [7:0] onetime_byte = {ot_lock | ot_locked, ot_en, 6'h00};
  // row commands need all three address bytes
  wire full_addr = (byte_cnt >= 3'h4);
  wire [3:0] ecc_now = ecc_code(ecc_count, ecc_uncorr);
  wire set_write = byte_done && (byte_cnt == 3'h2) && (cmd == `CMD_SET_FEAT);
  wire row_in_window = in_onetime(row[15:0]);
  // an empty frame would otherwise rerun the command left in cmd
  wire frame_act = frame_end && !op_in_progress && (byte_cnt != 3'h0);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wlatch <= 1'b0;
      e_fail <= 1'b0;
      p_fail <= 1'b0;
      ecc_res <= `ECC_NONE;
      ecc_ext <= 2'h0;
      ot_en <= 1'b0;
      ot_lock <= 1'b0;
      ot_locked <= 1'b0;
      lock_seen <= 1'b0;
      drive_level <= `DRV_RESET;
      op_in_progress <= 1'b0;
      op_start <= 1'b0;
      op_kind <= `OP_READ;
      op_row <= 24'h000000;
      op_onetime <= 1'b0;
      lock_commit <= 1'b0;
      rst_cnt <= 6'h00;
      rst_busy <= 1'b0;
    end else begin
      op_start <= 1'b0;
      lock_commit <= 1'b0;
      // nv_lock must be settled by the first edge after reset
      // R12 stored lock caught once after power-up
      if (!lock_seen) begin
        lock_seen <= 1'b1;
        ot_locked <= nv_lock;
      end
      // op_done during the reset wait is dropped; the engine is idle then
      if (rst_busy) begin
        if (rst_cnt == RST_CYC) begin
          rst_busy <= 1'b0;
          op_in_progress <= 1'b0;
        end else begin
          rst_cnt <= rst_cnt + 6'h01;
        end
      end else if (op_done && op_in_progress) begin
        op_in_progress <= 1'b0;
        if (op_kind == `OP_READ) begin
          // R21 R14 ecc fields refresh per read, one-time pages too
          ecc_res <= ecc_now[1:0];
          ecc_ext <= ecc_now[3:2];
        end else if (op_kind == `OP_PROG) begin
          p_fail <= op_fail;
          wlatch <= 1'b0;
        end else begin
          e_fail <= op_fail;
          wlatch <= 1'b0;
        end
      end
      // set-features acts on its data byte, busy or not
      // R2 R6 feature writes
      if (set_write) begin
        if (feat_addr == `FEAT_DRIVER)
          drive_level <= rx_byte[`DRV_HI:`DRV_LO];
        if (feat_addr == `FEAT_ONETIME) begin
          ot_en <= rx_byte[`OT_EN_BIT];
          ot_lock <= rx_byte[`OT_LOCK_BIT];
        end
      end
      if (frame_act) begin
        case (cmd)
          // R20 write latch commands
          `CMD_WR_EN: wlatch <= 1'b1;
          `CMD_WR_DIS: wlatch <= 1'b0;
          // R19 reset runs busy for a fixed time
          `CMD_SOFT_RESET: begin
            rst_busy <= 1'b1;
            rst_cnt <= 6'h00;
            op_in_progress <= 1'b1;
            wlatch <= 1'b0;
            e_fail <= 1'b0;
            p_fail <= 1'b0;
            ecc_res <= `ECC_NONE;
            ecc_ext <= 2'h0;
            ot_en <= 1'b0;
            ot_lock <= 1'b0;
          end
          `CMD_PAGE_READ: begin
            // R7 R9 R10 one-time reads only inside the page window
            if (full_addr && (!ot_en || row_in_window)) begin
              op_in_progress <= 1'b1;
              op_start <= 1'b1;
              op_kind <= `OP_READ;
              op_row <= row;
              op_onetime <= ot_en;
            end
          end
          `CMD_PROG_EXEC: begin
            if (full_addr && wlatch) begin
              if (ot_en && ot_lock && !ot_locked) begin
                // R11 lock becomes permanent, no array write
                ot_locked <= 1'b1;
                lock_commit <= 1'b1;
                wlatch <= 1'b0;
              end else if (ot_en && (ot_locked || !row_in_window)) begin
                // R12 R13 refuse once locked or outside window
                p_fail <= 1'b1;
                wlatch <= 1'b0;
              end else begin
                // R19 program busy
                p_fail <= 1'b0;
                op_in_progress <= 1'b1;
                op_start <= 1'b1;
                op_kind <= `OP_PROG;
                op_row <= row;
                op_onetime <= ot_en;
              end
            end
          end
          `CMD_BLOCK_ERASE: begin
            if (full_addr && wlatch) begin
              // R13 region never erased
              if (ot_en) begin
                e_fail <= 1'b1;
                wlatch <= 1'b0;
              end else begin
                e_fail <= 1'b0;
                op_in_progress <= 1'b1;
                op_start <= 1'b1;
                op_kind <= `OP_ERASE;
                op_row <= row;
                op_onetime <= 1'b0;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back shifter, mode 0: new bit after each falling edge
  reg [7:0] tx_shift;
  reg tx_pending;
  reg [7:0] tx_sel;
  // every byte after the address byte of a get-features frame is data
  wire data_phase = byte_done && (cmd == `CMD_GET_FEAT) && (byte_cnt != 3'h0);

  always @* begin
    case (feat_addr)
      // R1 status readable even while busy
      `FEAT_STATUS: tx_sel = status_byte;
      // R2 driver read-back
      `FEAT_DRIVER: tx_sel = driver_byte;
      `FEAT_ONETIME: tx_sel = onetime_byte;
      default: tx_sel = 8'h00;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_shift <= 8'h00;
      tx_pending <= 1'b0;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end else if (cs_s2) begin
      // miso keeps its last bit while released; the host ignores it
      tx_pending <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      if (data_phase)
        tx_pending <= 1'b1;
      if (byte_done && (byte_cnt == 3'h0) && (rx_byte == `CMD_GET_FEAT))
        tx_pending <= 1'b0;
      if (sclk_fall && tx_pending && (bit_cnt == 3'h0)) begin
        // fresh sample each byte so repeated reads track the busy bit
        tx_shift <= {tx_sel[6:0], 1'b0};
        miso <= tx_sel[7];
        miso_oe_n <= 1'b0;
      end else if (sclk_fall && tx_pending) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
        miso <= tx_shift[7];
      end
    end
  end

endmodule

/* verif/nand_ctrl_sva.sv */
`timescale 1ns/1ns
module nand_ctrl_sva (
  input wire core_clk,
  input wire rst,
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  input wire op_done,
  input wire [3:0] ecc_count,
  input wire ecc_uncorr,
  input wire op_fail,
  input wire nv_lock,
  input wire miso,
  input wire miso_oe_n,
  input wire op_start,
  input wire [1:0] op_kind,
  input wire [23:0] op_row,
  input wire op_onetime,
  input wire lock_commit,
  input wire [1:0] drive_level,
  input wire op_in_progress
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_START_BUSY: assert property
    (op_start |-> !$past(op_in_progress) ##[0:1] op_in_progress) else $error("no busy");
  AST_DONE_READY: assert property
    (op_in_progress && op_done |=> !op_in_progress) else $error("busy after done");
  AST_HOLD_OP: assert property
    (op_in_progress && $past(op_in_progress) |-> $stable(op_kind) && $stable(op_row))
    else $error("op moved");
  AST_OT_WINDOW: assert property
    (op_start && op_onetime |-> op_row[15:0] inside {[16'h0002:16'h000b]})
    else $error("page out of window");
  AST_OT_NO_ERASE: assert property
    (op_start && op_onetime |-> op_kind != 2'h2) else $error("erase of one-time page");
  AST_LOCK_IDLE: assert property
    (lock_commit |-> !op_start && !op_in_progress ##1 !lock_commit) else $error("lock pulse");
  AST_OE_RELEASE: assert property
    (cs_n [*8] |-> miso_oe_n) else $error("miso kept");
  AST_DRV_FRAME: assert property
    (!$stable(drive_level) |-> !$past(cs_n, 4)) else $error("drive moved");
  AST_START_FRAME: assert property
    (op_start |-> cs_n && $past(cs_n)) else $error("start in frame");
  cover property (op_start && op_onetime);
  cover property (lock_commit);
  cover property (op_done && ecc_uncorr);
endmodule
bind serial_nand_status_otp_ctrl nand_ctrl_sva u_sva (.core_clk(core_clk), .rst(rst),
  .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .op_done(op_done), .ecc_count(ecc_count),
  .ecc_uncorr(ecc_uncorr), .op_fail(op_fail), .nv_lock(nv_lock), .miso(miso),
  .miso_oe_n(miso_oe_n), .op_start(op_start), .op_kind(op_kind), .op_row(op_row),
  .op_onetime(op_onetime), .lock_commit(lock_commit), .drive_level(drive_level),
  .op_in_progress(op_in_progress));

/* verif/host_model.sv */
`timescale 1ns/1ns
module host_model (
  input wire core_clk,
  input wire miso,
  output reg sclk,
  output reg cs_n,
  output reg mosi,
  output reg [7:0] rx
);
  integer i;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx = 8'h00;
  end
  task xfer(input [31:0] v, input integer n);
    begin
      @(posedge core_clk) cs_n <= 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        mosi <= v[i];
        repeat (8) @(posedge core_clk);
        sclk <= 1'b1;
        rx <= {rx[6:0], miso};
        repeat (8) @(posedge core_clk);
        sclk <= 1'b0;
      end
      repeat (8) @(posedge core_clk);
      cs_n <= 1'b1;
      // released line flips so stale data never looks valid
      mosi <= ~mosi;
      repeat (20) @(posedge core_clk);
    end
  endtask
  // any first spare byte but the erased value marks a bad block
  function block_bad(input [7:0] spare);
    block_bad = (spare != 8'hff);
  endfunction
endmodule

/* verif/tb_serial_nand_status_otp_ctrl.sv */
`timescale 1ns/1ns
`include "nand_status_regs.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("mismatch t=%0t line %0d", $time, `__LINE__); end end
module tb_serial_nand_status_otp_ctrl;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg op_done = 1'b0;
  reg [3:0] ecc_count = 4'h0;
  reg ecc_uncorr = 1'b0;
  reg op_fail = 1'b0;
  reg nv_lock = 1'b0;
  wire sclk, cs_n, mosi, miso, miso_oe_n, op_start, op_onetime, lock_commit, op_in_progress;
  wire [1:0] op_kind, drive_level;
  wire [23:0] op_row;
  wire [7:0] rx;
  integer err_total = 0;
  integer n_compared = 0;
  integer n_start = 0;
  integer n_lock = 0;
  integer n_oe = 0;
  integer oe0;
  integer s, k;
  reg [1:0] kind_s;
  reg [23:0] row_s;
  reg ot_s;
  serial_nand_status_otp_ctrl DUT (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .op_done(op_done), .ecc_count(ecc_count), .ecc_uncorr(ecc_uncorr),
    .op_fail(op_fail), .nv_lock(nv_lock), .miso(miso), .miso_oe_n(miso_oe_n),
    .op_start(op_start), .op_kind(op_kind), .op_row(op_row), .op_onetime(op_onetime),
    .lock_commit(lock_commit), .drive_level(drive_level), .op_in_progress(op_in_progress));
  host_model HOST (.core_clk(core_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .rx(rx));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // op_start is a single-cycle pulse, so it is latched here
  always @(posedge core_clk) begin
    if (op_start) begin
      n_start <= n_start + 1;
      kind_s <= op_kind;
      row_s <= op_row;
      ot_s <= op_onetime;
    end
    if (lock_commit) n_lock <= n_lock + 1;
    if (!miso_oe_n) n_oe <= n_oe + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task do_reset(input lk);
    begin
      @(posedge core_clk) rst <= 1'b1;
      nv_lock <= lk;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task get(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      oe0 = n_oe;
      HOST.xfer({8'h00, `CMD_GET_FEAT, a, 8'h00}, 24);
      `CHK(rx & m, e)
      // driven from 3 cycles after the 16th fall until cs high is seen
      `CHK(n_oe - oe0, 136)
    end
  endtask
  task cmd(input [7:0] c, input [23:0] r, input integer n);
    HOST.xfer({c, r} >> (32 - n), n);
  endtask
  task finish_op(input [3:0] c, input u, input f);
    begin
      @(posedge core_clk) op_done <= 1'b1;
      ecc_count <= c;
      ecc_uncorr <= u;
      op_fail <= f;
      @(posedge core_clk) op_done <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  function [7:0] ecc_exp(input [3:0] c, input u);
    if (u) ecc_exp = 8'h20;
    else if (c == 4'h0) ecc_exp = 8'h00;
    else if (c <= 4'h4) ecc_exp = 8'h10;
    else if (c == 4'h8) ecc_exp = 8'h30;
    else ecc_exp = {c[1:0], 6'h10};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task t_reset_drive;
    begin
      `CHK(drive_level, `DRV_RESET)
      get(`FEAT_STATUS, 8'hff, 8'h00);
      get(8'h55, 8'hff, 8'h00);
      `CHK(HOST.block_bad(`BAD_MARK), 1'b1)
      `CHK(HOST.block_bad(`ERASED_BYTE), 1'b0)
      for (k = 0; k < 4; k = k + 1) begin
        cmd(`CMD_SET_FEAT, {`FEAT_DRIVER, 1'b0, k[1:0], 5'h00, 8'h00}, 24);
        `CHK(drive_level, k[1:0])
        get(`FEAT_DRIVER, 8'hff, {1'b0, k[1:0], 5'h00});
      end
    end
  endtask
  task t_ecc;
    begin
      for (k = 0; k < 10; k = k + 1) begin
        cmd(`CMD_PAGE_READ, 24'h000100 + k, 32);
        `CHK(row_s, 24'h000100 + k)
        if (k == 0) get(`FEAT_STATUS, 8'h01, 8'h01);
        finish_op((k == 9) ? 4'h0 : k[3:0], k == 9, 1'b0);
        get(`FEAT_STATUS, 8'hff, ecc_exp((k == 9) ? 4'h0 : k[3:0], k == 9));
      end
      cmd(`CMD_WR_EN, 24'h0, 8);
      get(`FEAT_STATUS, 8'hff, 8'h22);
      cmd(`CMD_SOFT_RESET, 24'h0, 8);
      get(`FEAT_STATUS, 8'hff, 8'h00);
      `CHK(drive_level, 2'h3)
    end
  endtask
  task t_prog;
    begin
      s = n_start;
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_WR_DIS, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000040, 32);
      `CHK(n_start, s)
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000040, 32);
      `CHK(kind_s, `OP_PROG)
      get(`FEAT_STATUS, 8'hff, 8'h03);
      finish_op(4'h0, 1'b0, 1'b1);
      get(`FEAT_STATUS, 8'hff, 8'h08);
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_BLOCK_ERASE, 24'h000040, 32);
      `CHK(kind_s, `OP_ERASE)
      finish_op(4'h0, 1'b0, 1'b0);
      get(`FEAT_STATUS, 8'h07, 8'h00);
    end
  endtask
  task t_otp;
    begin
      cmd(`CMD_SET_FEAT, {`FEAT_ONETIME, 8'h40, 8'h00}, 24);
      cmd(`CMD_PAGE_READ, 24'h000002, 32);
      `CHK(ot_s, 1'b1)
      finish_op(4'h0, 1'b0, 1'b0);
      for (k = 2; k < 4; k = k + 1) begin
        cmd(`CMD_WR_EN, 24'h0, 8);
        cmd(`CMD_PROG_EXEC, k, 32);
        `CHK(row_s[15:0], k[15:0])
        finish_op(4'h0, 1'b0, 1'b0);
      end
      s = n_start;
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h00000c, 32);
      get(`FEAT_STATUS, 8'h08, 8'h08);
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_BLOCK_ERASE, 24'h000040, 32);
      get(`FEAT_STATUS, 8'h04, 8'h04);
      cmd(`CMD_SET_FEAT, {`FEAT_ONETIME, 8'hc0, 8'h00}, 24);
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000004, 32);
      `CHK(n_lock, 1)
      cmd(`CMD_SOFT_RESET, 24'h0, 8);
      get(`FEAT_ONETIME, 8'hc0, 8'h80);
      get(`FEAT_STATUS, 8'h08, 8'h00);
      cmd(`CMD_SET_FEAT, {`FEAT_ONETIME, 8'h40, 8'h00}, 24);
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000005, 32);
      get(`FEAT_STATUS, 8'h08, 8'h08);
      `CHK(n_start, s)
    end
  endtask
  task t_power_lock;
    begin
      do_reset(1'b1);
      `CHK(drive_level, `DRV_RESET)
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000002, 32);
      `CHK(ot_s, 1'b0)
      finish_op(4'h0, 1'b0, 1'b0);
      s = n_start;
      cmd(`CMD_SET_FEAT, {`FEAT_ONETIME, 8'h40, 8'h00}, 24);
      cmd(`CMD_WR_EN, 24'h0, 8);
      cmd(`CMD_PROG_EXEC, 24'h000002, 32);
      `CHK(n_start, s)
      cmd(`CMD_PAGE_READ, 24'h000002, 32);
      `CHK(n_start, s + 1)
      finish_op(4'h0, 1'b0, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("errors %0d compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    do_reset(1'b0);
    t_reset_drive;
    t_ecc;
    t_prog;
    t_otp;
    t_power_lock;
    final_report;
  end
  // about 29k cycles expected; 60k cycles means a hang
  initial begin
    #600000;
    err_total = err_total + 1;
    final_report;
  end
endmodule
